/* File: pkg/mww_pkg.sv */
package mww_pkg;
    localparam int CLK_NS = 20;
    localparam logic [7:0] OFS_PATTERN = 8'h70;
    localparam logic [7:0] OFS_DOG_CTL = 8'h78;
    localparam logic [7:0] OFS_ADD_STS = 8'h80;
    localparam logic [7:0] OFS_ADD_EN = 8'h84;
    localparam logic [7:0] OFS_CMD = 8'h88;
    localparam logic [7:0] OFS_WAKE_FLAGS = 8'hc0;
    localparam int PAT_WORDS = 25;
    localparam int PAT_MASK_WORDS = 4;
    localparam int PAT_CRC_LSB = 16;
    localparam int PAT_OFS_W = 8;
    localparam logic [15:0] CRC_PRESET_ONES = 16'hffff;
    localparam logic [15:0] CRC_PRESET_ZERO = 16'h0000;
    localparam int DOG_RWR = 5;
    localparam int DOG_RWD = 4;
    localparam int DOG_TSEL = 2;
    localparam int DOG_NOHOLD = 1;
    localparam int DOG_GUARD_OFF = 0;
    localparam logic [5:0] DOG_RST = 6'h00;
    localparam logic [5:0] DOG_WMASK = 6'h37;
    localparam int RX_DOG_BYTES = 2560;
    localparam logic [5:0] RX_REL_SHORT = 6'h18;
    localparam logic [5:0] RX_REL_LONG = 6'h30;
    localparam int ST_TX_EARLY_FLAG = 31;
    localparam int ST_RX_EARLY_FLAG = 30;
    localparam int ST_LCS = 29;
    localparam int ST_TDIS = 28;
    localparam int ST_PFR = 26;
    localparam int ST_ANS = 16;
    localparam int ST_AAS = 15;
    localparam int MAIN_W = 15;
    localparam logic [31:0] ADD_MASK = 32'hf4018000;
    localparam int CMD_HOLD = 24;
    localparam int CMD_LED4 = 23;
    localparam int CMD_RFS = 21;
    localparam int CMD_PM = 19;
    localparam int CMD_LEGACY = 18;
    localparam int CMD_FORCE = 7;
    localparam int CMD_PCLR = 6;
    localparam int CMD_PAUSE = 5;
    localparam logic [15:0] CMD_HI_RST = 16'ha05c;
    localparam logic [15:0] CMD_HI_WMASK = 16'h83e6;
    localparam logic [7:0] CMD_LO_RST = 8'h04;
    localparam logic [1:0] RFS_1K = 2'b11;
    localparam logic [1:0] RFS_2K = 2'b10;
    localparam longint JAB_100_NS = 2_600_000;
    localparam longint JAB_10_NS = 26_000_000;
    localparam longint HOLD_100_NS = 42_000_000;
    localparam longint HOLD_10_NS = 420_000_000;
    localparam int JAB_100_CYC = int'(JAB_100_NS / CLK_NS);
    localparam int JAB_10_CYC = int'(JAB_10_NS / CLK_NS);
    localparam int HOLD_100_CYC = int'(HOLD_100_NS / CLK_NS);
    localparam int HOLD_10_CYC = int'(HOLD_10_NS / CLK_NS);
    localparam int JAB_BYTES = 2560;
    typedef enum logic [1:0] {
        MWW_JB_IDLE = 2'b00,
        MWW_JB_RUN = 2'b01,
        MWW_JB_CUT = 2'b10,
        MWW_JB_HOLD = 2'b11
    } mww_jab_t;
endpackage

/* File: hw/mww_regs.sv */
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module mww_regs
    import mww_pkg::*;
#(
    parameter int JAB100 = JAB_100_CYC,
    parameter int JAB10 = JAB_10_CYC,
    parameter int HOLD100 = HOLD_100_CYC,
    parameter int HOLD10 = HOLD_10_CYC,
    parameter logic [7:0] CAP_PTR = 8'h40
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic por_b_i,
    input wire logic sw_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic wake_frame_i,
    input wire logic wake_packet_i,
    input wire logic link_change_i,
    input wire logic wake_frame_en_i,
    input wire logic wake_packet_en_i,
    input wire logic link_change_en_i,
    input wire logic wake_status_clr_i,
    input wire logic power_up_i,
    input wire logic pattern_crc_preset_sel_i,
    input wire logic [4:0] pat_rd_addr_i,
    output logic [31:0] pat_rd_data_o,
    output logic [15:0] pat_crc_o,
    output logic [7:0] pat_offset_o,
    output logic [15:0] crc_preset_o,
    input wire logic carrier_i,
    input wire logic rx_byte_i,
    input wire logic bit_tick_i,
    output logic rx_dog_expired_o,
    input wire logic tx_active_i,
    input wire logic tx_byte_i,
    input wire logic speed100_i,
    output logic tx_enable_o,
    output logic babble_cut_o,
    input wire logic tx_early_evt_i,
    input wire logic rx_early_evt_i,
    input wire logic pause_frame_i,
    input wire logic tx_defer_evt_i,
    input wire logic link_int_evt_i,
    input wire logic [14:0] main_sts_i,
    input wire logic [14:0] main_en_i,
    output logic [14:0] main_sts_clr_o,
    output logic main_en_wr_o,
    output logic [14:0] main_en_wdata_o,
    output logic normal_sum_o,
    output logic abnormal_sum_o,
    input wire logic ee_load_i,
    input wire logic [15:0] ee_data_i,
    input wire logic an_done_i,
    input wire logic an_pause_i,
    input wire logic link_i,
    input wire logic activity_i,
    input wire logic duplex_i,
    input wire logic collision_i,
    output logic [3:0] led_o,
    output logic rx_fifo_1k_o,
    output logic [7:0] cap_ptr_o,
    output logic wake_packet_default_o,
    output logic pause_en_o,
    output logic wake_req_o
);
    logic [31:0] pat_mem [PAT_WORDS];
    logic [4:0] pat_ptr;
    logic [2:0] wake_flags;
    logic wake_stat;
    logic [5:0] dog_ctl;
    logic [31:0] add_sts;
    logic [31:0] add_en;
    logic [15:0] cmd_hi;
    logic [7:0] cmd_lo;
    logic [11:0] rx_cnt;
    logic [5:0] rel_cnt;
    logic carrier_q;
    mww_jab_t jab_st;
    logic [24:0] jab_cnt;
    logic [24:0] next_jab_cnt;
    logic [31:0] sts_set;
    logic [31:0] next_sts;
    logic [2:0] wake_set;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    wire wr_pat = wr_i && hit(addr_i, OFS_PATTERN);
    wire wr_dog = wr_i && hit(addr_i, OFS_DOG_CTL);
    wire wr_sts = wr_i && hit(addr_i, OFS_ADD_STS);
    wire wr_en = wr_i && hit(addr_i, OFS_ADD_EN);
    wire wr_cmd = wr_i && hit(addr_i, OFS_CMD);
    wire wr_wake = wr_i && hit(addr_i, OFS_WAKE_FLAGS);
    wire pm_on = cmd_hi[CMD_PM-16];

    // wake flags live on power-up reset only so hw/sw resets keep them
    assign wake_set = {wake_frame_i, wake_packet_i, link_change_i};
    always_ff @(posedge clk_sys_i or negedge por_b_i) begin
        if (!por_b_i) begin
            wake_flags <= 3'h0;
        end else begin
            // set wins over a same-cycle write-one clear
            wake_flags <= (wake_flags & ~({3{wr_wake}} & wdata_i[2:0]))
                | wake_set;
        end
    end

    always_ff @(posedge clk_sys_i or negedge por_b_i) begin
        if (!por_b_i) begin
            wake_stat <= 1'b0;
        end else if ((wake_frame_i && wake_frame_en_i)
                || (wake_packet_i && wake_packet_en_i)
                || (link_change_i && link_change_en_i)) begin
            wake_stat <= 1'b1;
        end else if (wake_status_clr_i) begin
            wake_stat <= 1'b0;
        end else if (power_up_i && !cmd_hi[CMD_HOLD-16]) begin
            wake_stat <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge por_b_i) begin
        if (!por_b_i) begin
            wake_req_o <= 1'b0;
        end else begin
            wake_req_o <= cmd_lo[CMD_FORCE] | wake_stat;
        end
    end

    // pattern store: no reset, contents are loaded by software
    always_ff @(posedge clk_sys_i) begin
        if (wr_pat) begin
            pat_mem[pat_ptr] <= wdata_i;
        end
        pat_rd_data_o <= pat_mem[pat_rd_addr_i];
        pat_crc_o <= pat_mem[pat_rd_addr_i][31:PAT_CRC_LSB];
        pat_offset_o <= pat_mem[pat_rd_addr_i][PAT_OFS_W-1:0];
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pat_ptr <= 5'h00;
        end else if (sw_rst_i || cmd_lo[CMD_PCLR]) begin
            pat_ptr <= 5'h00;
        end else if (wr_pat) begin
            // wrap keeps a 26th write inside the filter area
            if (pat_ptr == 5'(PAT_WORDS - 1)) begin
                pat_ptr <= 5'h00;
            end else begin
                pat_ptr <= pat_ptr + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crc_preset_o <= CRC_PRESET_ZERO;
        end else begin
            crc_preset_o <= pattern_crc_preset_sel_i ? CRC_PRESET_ONES
                : CRC_PRESET_ZERO;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dog_ctl <= DOG_RST;
        end else if (sw_rst_i) begin
            dog_ctl <= DOG_RST;
        end else if (wr_dog) begin
            dog_ctl <= wdata_i[5:0] & DOG_WMASK;
        end
    end

    // receive watchdog
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            carrier_q <= 1'b0;
            rx_cnt <= 12'h000;
            rel_cnt <= 6'h00;
            rx_dog_expired_o <= 1'b0;
        end else begin
            carrier_q <= carrier_i;
            if (carrier_i && !carrier_q && !rx_dog_expired_o) begin
                rx_cnt <= 12'h000;
            end else if (carrier_i && rx_byte_i && rx_cnt != 12'hfff) begin
                rx_cnt <= rx_cnt + 12'h001;
            end
            // the byte that crosses the limit expires at once
            if (!dog_ctl[DOG_RWD] && carrier_i
                    && (rx_cnt > 12'(RX_DOG_BYTES)
                    || (rx_byte_i && rx_cnt == 12'(RX_DOG_BYTES)))) begin
                rx_dog_expired_o <= 1'b1;
            end else if (dog_ctl[DOG_RWD]) begin
                rx_dog_expired_o <= 1'b0;
            end else if (rx_dog_expired_o && !carrier_i && bit_tick_i) begin
                if (rel_cnt + 6'h01 >= (dog_ctl[DOG_RWR] ? RX_REL_LONG
                        : RX_REL_SHORT)) begin
                    rx_dog_expired_o <= 1'b0;
                    rx_cnt <= 12'h000;
                end
            end
            if (carrier_i || !rx_dog_expired_o) begin
                rel_cnt <= 6'h00;
            end else if (bit_tick_i) begin
                rel_cnt <= rel_cnt + 6'h01;
            end
        end
    end

    // transmit jabber: counts cycles, or bytes in byte-count mode
    always_comb begin
        next_jab_cnt = jab_cnt;
        if (dog_ctl[DOG_TSEL]) begin
            if (tx_byte_i) begin
                next_jab_cnt = jab_cnt + 25'h1;
            end
        end else begin
            next_jab_cnt = jab_cnt + 25'h1;
        end
    end

    wire [24:0] jab_lim = dog_ctl[DOG_TSEL] ? 25'(JAB_BYTES)
        : (speed100_i ? 25'(JAB100) : 25'(JAB10));
    wire [24:0] hold_lim = speed100_i ? 25'(HOLD100) : 25'(HOLD10);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            jab_st <= MWW_JB_IDLE;
            jab_cnt <= 25'h0;
        end else begin
            case (jab_st)
                MWW_JB_IDLE: begin
                    jab_cnt <= 25'h0;
                    if (tx_active_i && !dog_ctl[DOG_GUARD_OFF]) begin
                        jab_st <= MWW_JB_RUN;
                    end
                end
                MWW_JB_RUN: begin
                    jab_cnt <= next_jab_cnt;
                    if (!tx_active_i || dog_ctl[DOG_GUARD_OFF]) begin
                        jab_st <= MWW_JB_IDLE;
                    end else if (next_jab_cnt >= jab_lim) begin
                        jab_st <= MWW_JB_CUT;
                    end
                end
                MWW_JB_CUT: begin
                    jab_cnt <= 25'h0;
                    if (dog_ctl[DOG_NOHOLD] || dog_ctl[DOG_GUARD_OFF]) begin
                        jab_st <= MWW_JB_IDLE;
                    end else begin
                        jab_st <= MWW_JB_HOLD;
                    end
                end
                MWW_JB_HOLD: begin
                    jab_cnt <= jab_cnt + 25'h1;
                    if (dog_ctl[DOG_NOHOLD]
                            || jab_cnt + 25'h1 >= hold_lim) begin
                        jab_st <= MWW_JB_IDLE;
                    end
                end
                default: begin
                    jab_st <= MWW_JB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_enable_o <= 1'b1;
            babble_cut_o <= 1'b0;
        end else begin
            tx_enable_o <= !(jab_st == MWW_JB_CUT || jab_st == MWW_JB_HOLD);
            babble_cut_o <= (jab_st == MWW_JB_CUT);
        end
    end

    // added interrupt status, set beats write-one clear
    always_comb begin
        sts_set = 32'h0;
        sts_set[ST_TX_EARLY_FLAG] = tx_early_evt_i && add_en[ST_TX_EARLY_FLAG];
        sts_set[ST_RX_EARLY_FLAG] = rx_early_evt_i && add_en[ST_RX_EARLY_FLAG];
        sts_set[ST_PFR] = pause_frame_i && cmd_lo[CMD_PAUSE];
        sts_set[ST_LCS] = link_int_evt_i && add_en[ST_LCS];
        sts_set[ST_TDIS] = tx_defer_evt_i && add_en[ST_TDIS];
        sts_set[ST_ANS] = sts_set[ST_TX_EARLY_FLAG] || sts_set[ST_RX_EARLY_FLAG];
        sts_set[ST_AAS] = sts_set[ST_PFR] || sts_set[ST_LCS]
            || sts_set[ST_TDIS];
        next_sts = add_sts & ~({32{wr_sts}} & wdata_i) & ADD_MASK;
        next_sts = next_sts | sts_set;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            add_sts <= 32'h0;
            add_en <= 32'h0;
        end else if (sw_rst_i) begin
            add_sts <= 32'h0;
            add_en <= 32'h0;
        end else begin
            add_sts <= next_sts;
            if (wr_en) begin
                add_en <= wdata_i & ADD_MASK;
            end
        end
    end

    // low bits forward to the main status and enable registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            main_sts_clr_o <= 15'h0;
            main_en_wr_o <= 1'b0;
            main_en_wdata_o <= 15'h0;
        end else begin
            main_sts_clr_o <= wr_sts ? wdata_i[MAIN_W-1:0] : 15'h0;
            main_en_wr_o <= wr_en;
            main_en_wdata_o <= wdata_i[MAIN_W-1:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            normal_sum_o <= 1'b0;
            abnormal_sum_o <= 1'b0;
        end else begin
            normal_sum_o <= add_en[ST_ANS]
                && ((add_sts[ST_TX_EARLY_FLAG] && add_en[ST_TX_EARLY_FLAG])
                || (add_sts[ST_RX_EARLY_FLAG] && add_en[ST_RX_EARLY_FLAG]));
            abnormal_sum_o <= add_en[ST_AAS]
                && ((add_sts[ST_PFR] && add_en[ST_PFR])
                || (add_sts[ST_TDIS] && add_en[ST_TDIS])
                || (add_sts[ST_LCS] && add_en[ST_LCS]));
        end
    end

    // command register upper half; eeprom reload overrides a same-cycle write to it
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_hi <= CMD_HI_RST;
        end else if (ee_load_i) begin
            cmd_hi <= ee_data_i;
        end else if (wr_cmd) begin
            cmd_hi <= (cmd_hi & ~CMD_HI_WMASK)
                | (wdata_i[31:16] & CMD_HI_WMASK);
            if (wdata_i[CMD_RFS+1:CMD_RFS] != RFS_1K
                    && wdata_i[CMD_RFS+1:CMD_RFS] != RFS_2K) begin
                cmd_hi[CMD_RFS-15:CMD_RFS-16]
                    <= cmd_hi[CMD_RFS-15:CMD_RFS-16];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_lo <= CMD_LO_RST;
        end else begin
            if (wr_cmd) begin
                cmd_lo <= wdata_i[7:0];
            end
            if (!an_done_i) begin
                cmd_lo[CMD_PAUSE] <= an_pause_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_o <= 4'h0;
            rx_fifo_1k_o <= 1'b0;
            cap_ptr_o <= 8'h00;
            wake_packet_default_o <= 1'b0;
            pause_en_o <= 1'b0;
        end else begin
            if (cmd_hi[CMD_LED4-16]) begin
                led_o <= {duplex_i | collision_i, activity_i,
                    link_i & ~speed100_i, link_i & speed100_i};
            end else begin
                led_o <= {1'b0, duplex_i | collision_i,
                    link_i & ~activity_i, speed100_i};
            end
            rx_fifo_1k_o <= (cmd_hi[CMD_RFS-15:CMD_RFS-16] == RFS_1K);
            cap_ptr_o <= pm_on ? CAP_PTR : 8'h00;
            wake_packet_default_o <= pm_on && cmd_hi[CMD_LEGACY-16];
            pause_en_o <= cmd_lo[CMD_PAUSE];
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0;
        end else if (!rd_i) begin
            rdata_o <= 32'h0;
        end else begin
            case (addr_i)
                OFS_DOG_CTL: rdata_o <= {26'h0, dog_ctl};
                OFS_ADD_STS: rdata_o <= {add_sts[31:15], main_sts_i};
                OFS_ADD_EN: rdata_o <= {add_en[31:15], main_en_i};
                OFS_CMD: rdata_o <= {cmd_hi, 8'h00, cmd_lo};
                OFS_WAKE_FLAGS: rdata_o <= {28'h0, wake_stat, wake_flags};
                default: rdata_o <= 32'h0;
            endcase
        end
    end

    chk_wake_flag_set: assert property (@(posedge clk_sys_i)
        disable iff (!por_b_i) wake_frame_i |=> wake_flags[2])
        else $error("wake frame flag not set");
    chk_wake_flag_hold: assert property (@(posedge clk_sys_i)
        disable iff (!por_b_i) (wake_flags[1] && !wr_wake) |=> wake_flags[1])
        else $error("wake packet flag dropped without clear");
    chk_ptr_clear: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) cmd_lo[CMD_PCLR] |=> pat_ptr == 5'h00)
        else $error("pattern pointer not cleared");
    chk_ptr_step: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (wr_pat && !cmd_lo[CMD_PCLR] && !sw_rst_i && pat_ptr < 5'd24)
        |=> pat_ptr == $past(pat_ptr) + 5'h01)
        else $error("pattern pointer did not advance");
    chk_ptr_range: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) pat_ptr < 5'd25)
        else $error("pattern pointer out of range");
    chk_dog_off: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) dog_ctl[DOG_RWD] |=> !rx_dog_expired_o)
        else $error("watchdog expired while disabled");
    chk_jab_cut_out: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) (jab_st == MWW_JB_CUT) |=> !tx_enable_o)
        else $error("transmit not cut after jabber");
    chk_jab_nohold: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i)
        (jab_st == MWW_JB_CUT && dog_ctl[DOG_NOHOLD])
        |=> jab_st == MWW_JB_IDLE ##1 tx_enable_o)
        else $error("no-holdoff did not re-enable");
    chk_tx_early: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i || sw_rst_i)
        (tx_early_evt_i && add_en[ST_TX_EARLY_FLAG]) |=> add_sts[ST_TX_EARLY_FLAG]
        && add_sts[ST_ANS])
        else $error("transmit early status not latched");
    chk_pause_gate: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i || sw_rst_i)
        (!add_sts[ST_PFR] && !cmd_lo[CMD_PAUSE]) |=> !add_sts[ST_PFR])
        else $error("pause status set while disabled");
    chk_cap_ptr: assert property (@(posedge clk_sys_i)
        disable iff (!rst_b_i) !pm_on |=> cap_ptr_o == 8'h00)
        else $error("capability pointer not zero");
    chk_force_pin: assert property (@(posedge clk_sys_i)
        disable iff (!por_b_i) cmd_lo[CMD_FORCE] |=> wake_req_o)
        else $error("wake pin not forced");
endmodule

/* File: verification/mww_medium.sv */
`timescale 1ns/10ps
module mww_medium (
    input wire logic clk_i,
    input wire logic [15:0] len_i,
    input wire logic go_i,
    output logic crs_o,
    output logic byte_o,
    output logic tick_o
);
    // line bit clock runs free, so release timing sees ticks after carrier
    logic [18:0] bits = '0;
    assign tick_o = 1'b1;
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            bits <= {len_i, 3'h0};
        end else if (bits != '0) begin
            bits <= bits - 19'h1;
        end
    end
    assign crs_o = bits != '0;
    assign byte_o = crs_o && bits[2:0] == 3'h1;
endmodule

/* File: verification/test_mww_regs.sv */
`timescale 1ns/10ps
module test_mww_regs;
    import mww_pkg::*;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, por_b_i = 1'b0, wr_i = 1'b0;
    logic rd_i = 1'b0, power_up_i = 1'b0, pattern_crc_preset_sel_i = 1'b0;
    logic tx_active_i = 1'b0, speed100_i = 1'b1, ee_load_i = 1'b0;
    logic an_done_i = 1'b0, an_pause_i = 1'b0, link_i = 1'b0, go = 1'b0;
    logic duplex_i = 1'b0, rx_dog_expired_o, tx_enable_o, babble_cut_o;
    logic normal_sum_o, rx_fifo_1k_o, wake_packet_default_o, pause_en_o;
    logic wake_req_o, carrier_i, rx_byte_i, bit_tick_i;
    logic sw_rst_i = 1'b0, wake_status_clr_i = 1'b0, tx_byte_i = 1'b0;
    logic activity_i = 1'b0, collision_i = 1'b0, abnormal_sum_o;
    logic [7:0] addr_i = '0, ev = '0, pat_offset_o, cap_ptr_o;
    logic [31:0] wdata_i = '0, s = 32'h09d98554, d, base, rdata_o;
    logic [31:0] pat_rd_data_o, pw[PAT_WORDS + 1];
    logic [14:0] main_sts_i = '0, main_en_i = '0, main_sts_clr_o;
    logic [15:0] ee_data_i = '0, len = '0, pat_crc_o, crc_preset_o;
    logic [4:0] pat_rd_addr_i = '0;
    logic [3:0] led_o;
    logic [2:0] wen = '0;
    logic [1:0] f;
    int fail_count = 0, checks_done = 0;
    mww_regs #(.JAB100(20), .JAB10(40), .HOLD100(30), .HOLD10(60)) uut (
        .clk_sys_i, .rst_b_i, .por_b_i, .sw_rst_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .wake_frame_i(ev[0]), .wake_packet_i(ev[1]),
        .link_change_i(ev[2]), .wake_frame_en_i(wen[0]),
        .wake_packet_en_i(wen[1]), .link_change_en_i(wen[2]),
        .wake_status_clr_i, .power_up_i, .pattern_crc_preset_sel_i,
        .pat_rd_addr_i, .pat_rd_data_o, .pat_crc_o, .pat_offset_o,
        .crc_preset_o, .carrier_i, .rx_byte_i, .bit_tick_i, .rx_dog_expired_o,
        .tx_active_i, .tx_byte_i, .speed100_i, .tx_enable_o,
        .babble_cut_o, .tx_early_evt_i(ev[3]), .rx_early_evt_i(ev[4]),
        .pause_frame_i(ev[5]), .tx_defer_evt_i(ev[6]), .link_int_evt_i(ev[7]),
        .main_sts_i, .main_en_i, .main_sts_clr_o, .main_en_wr_o(),
        .main_en_wdata_o(), .normal_sum_o, .abnormal_sum_o, .ee_load_i,
        .ee_data_i, .an_done_i, .an_pause_i, .link_i, .activity_i,
        .duplex_i, .collision_i, .led_o, .rx_fifo_1k_o, .cap_ptr_o,
        .wake_packet_default_o, .pause_en_o, .wake_req_o);
    mww_medium far (.clk_i(clk_sys_i), .len_i(len), .go_i(go),
        .crs_o(carrier_i), .byte_o(rx_byte_i), .tick_o(bit_tick_i));
    function automatic logic [31:0] nx(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // reserved size codes leave the old field in place
    function automatic logic [1:0] fx(logic [1:0] o, c);
        return c[1] ? c : o;
    endfunction
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] v, e);
        checks_done++;
        if (v !== e) begin
            fail_count++;
            $display("unexpected %s exp %h seen %h", n, e, v);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wt(ref logic v, input int n);
        while (v !== 1'b1 && n > 0) begin
            @(posedge clk_sys_i);
            #1 n--;
        end
        if (v !== 1'b1) begin
            fail_count++;
            results();
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_sys_i) wr_i <= 1'b0;
    endtask
    task automatic rc(logic [7:0] a, logic [31:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i) rd_i <= 1'b0;
        #1 chk("rdata", rdata_o, e);
    endtask
    task automatic pulse(logic [7:0] m);
        @(posedge clk_sys_i) ev <= m;
        @(posedge clk_sys_i) ev <= '0;
    endtask
    initial begin
        forever #(CLK_NS / 2) clk_sys_i = ~clk_sys_i;
    end
    initial begin
        base = {CMD_HI_RST, 8'h00, CMD_LO_RST};
        s = nx(s);
        {main_en_i, main_sts_i} = s[29:0];
        f = RFS_2K;
        cyc(5);
        rst_b_i <= 1'b1;
        por_b_i <= 1'b1;
        rc(OFS_CMD, base);
        rc(OFS_ADD_STS, 32'(main_sts_i));
        rc(8'h10, '0);
        chk("cap", cap_ptr_o, 8'h40);
        s = nx(s);
        wr(OFS_DOG_CTL, s);
        rc(OFS_DOG_CTL, s & 32'(DOG_WMASK));
        for (int c = 3; c >= 0; c--) begin
            d = base;
            d[22:21] = 2'(c);
            wr(OFS_CMD, d);
            f = fx(f, 2'(c));
            rc(OFS_CMD, {base[31:23], f, base[20:0]});
            chk("fifo", rx_fifo_1k_o, f == RFS_1K);
        end
        wr(OFS_CMD, base | 32'h80);
        cyc(2);
        #1 chk("req", wake_req_o, 1'b1);
        repeat (3) wr(OFS_PATTERN, '1);
        wr(OFS_CMD, base | 32'h40);
        wr(OFS_CMD, base);
        #1 chk("req", wake_req_o, 1'b0);
        for (int i = 0; i <= PAT_WORDS; i++) begin
            s = nx(s);
            pw[i] = s;
            wr(OFS_PATTERN, s);
        end
        pw[0] = pw[PAT_WORDS];
        for (int i = 0; i < PAT_WORDS; i++) begin
            @(posedge clk_sys_i) pat_rd_addr_i <= 5'(i);
            @(posedge clk_sys_i);
            #1 chk("pat", pat_rd_data_o, pw[i]);
            d = pw[i] & 32'hffff00ff;
            chk("crc", {pat_crc_o, 8'h00, pat_offset_o}, d);
        end
        wr(OFS_ADD_EN, ADD_MASK | main_en_i);
        rc(OFS_ADD_EN, 32'hf4018000 | main_en_i);
        pulse(8'hf8);
        rc(OFS_ADD_STS, 32'hf0018000 | main_sts_i);
        chk("nsum", normal_sum_o, 1'b1);
        chk("asum", abnormal_sum_o, 1'b1);
        wr(OFS_ADD_STS, 32'hf0018005);
        #1 chk("clr", main_sts_clr_o, 15'h5);
        rc(OFS_ADD_STS, 32'(main_sts_i));
        @(posedge clk_sys_i) wen <= 3'h7;
        pulse(8'h07);
        rc(OFS_WAKE_FLAGS, 32'hf);
        @(posedge clk_sys_i) rst_b_i <= 1'b0;
        @(posedge clk_sys_i) rst_b_i <= 1'b1;
        rc(OFS_WAKE_FLAGS, 32'hf);
        @(posedge clk_sys_i) sw_rst_i <= 1'b1;
        @(posedge clk_sys_i) sw_rst_i <= 1'b0;
        rc(OFS_WAKE_FLAGS, 32'hf);
        chk("req", wake_req_o, 1'b1);
        wr(OFS_WAKE_FLAGS, 32'h7);
        rc(OFS_WAKE_FLAGS, 32'h8);
        @(posedge clk_sys_i) power_up_i <= 1'b1;
        @(posedge clk_sys_i) power_up_i <= 1'b0;
        rc(OFS_WAKE_FLAGS, '0);
        chk("req", wake_req_o, 1'b0);
        wr(OFS_CMD, base | 32'h01000000);
        pulse(8'h01);
        @(posedge clk_sys_i) power_up_i <= 1'b1;
        @(posedge clk_sys_i) power_up_i <= 1'b0;
        rc(OFS_WAKE_FLAGS, 32'hc);
        @(posedge clk_sys_i) wake_status_clr_i <= 1'b1;
        @(posedge clk_sys_i) wake_status_clr_i <= 1'b0;
        rc(OFS_WAKE_FLAGS, 32'h4);
        @(posedge clk_sys_i) {link_i, duplex_i, an_pause_i} <= 3'h7;
        pattern_crc_preset_sel_i <= 1'b1;
        cyc(2);
        #1 chk("led", led_o, 4'h7);
        chk("pause", pause_en_o, 1'b1);
        chk("preset", crc_preset_o, CRC_PRESET_ONES);
        chk("wdef", wake_packet_default_o, 1'b1);
        pulse(8'h20);
        rc(OFS_ADD_STS, 32'h04008000 | main_sts_i);
        @(posedge clk_sys_i) {ee_load_i, ee_data_i} <= {1'b1, 16'h20d4};
        {activity_i, duplex_i, collision_i} <= 3'b101;
        @(posedge clk_sys_i) ee_load_i <= 1'b0;
        cyc(2);
        #1 chk("led", led_o, 4'hd);
        chk("cap", cap_ptr_o, 8'h00);
        rc(OFS_CMD, 32'h20d40024);
        @(posedge clk_sys_i) tx_active_i <= 1'b1;
        wt(babble_cut_o, 40);
        @(posedge clk_sys_i) tx_active_i <= 1'b0;
        cyc(18);
        #1 chk("txen", tx_enable_o, 1'b0);
        wt(tx_enable_o, 30);
        wr(OFS_DOG_CTL, 32'h6);
        @(posedge clk_sys_i) tx_active_i <= 1'b1;
        cyc(40);
        #1 chk("txen", tx_enable_o, 1'b1);
        @(posedge clk_sys_i) tx_byte_i <= 1'b1;
        wt(babble_cut_o, 2600);
        chk("txen", tx_enable_o, 1'b0);
        wt(tx_enable_o, 3);
        @(posedge clk_sys_i) {tx_active_i, tx_byte_i} <= 2'b00;
        @(posedge clk_sys_i) {go, len} <= {1'b1, 16'h0a01};
        @(posedge clk_sys_i) go <= 1'b0;
        cyc(20490);
        #1 chk("dog", rx_dog_expired_o, 1'b1);
        cyc(40);
        #1 chk("dog", rx_dog_expired_o, 1'b0);
        results();
    end
endmodule
